// [rtl/sef_dev.sv]
// Function
// RULE_01 - Controller appends even parity bit to writes
// RULE_02 - Parity checked only on 17-bit mode writes
// RULE_03 - Bad parity discards write, sets parity flag
// RULE_04 - Write during memory busy sets busy flag
// RULE_05 - Controller avoids writes while memory busy
// RULE_06 - Controller compares returned value with written
// RULE_07 - Restore CRC mismatch sets restore flag
// RULE_08 - Error pin high while any flag set
// RULE_09 - Clear command clears flags and pin
// RULE_10 - Pull setting selects input pulls or float
// RULE_11 - Data out driven while select low
// RULE_12 - Idle data out pulled down or floating
// RULE_13 - Flags readable in register 26
// RULE_14 - Flags sticky until clear or reset
module sef_dev (
   input wire logic CLOCK,
   input wire logic NRST,
   input wire logic NVM_FAULT,
   sef_link_if.dev LINK
);
   import sef_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   typedef enum logic [1:0] {NV_IDLE, NV_STORE, NV_RESTORE} sef_nv_e;
   localparam int STEP_W = $clog2(NVM_STEP_CYC);
   sef_nv_e nv_st;
   logic cs_s, sclk_s, mosi_s, fault_s;
   logic cs_prev, sclk_prev;
   logic [16:0] rx_shift;
   logic [4:0] bit_cnt;
   logic [15:0] tx_shift;
   logic [15:0] resp;
   logic [2:0] flags;
   logic [7:0] regs [NUM_REGS];
   logic [7:0] nvm [NUM_REGS];
   logic [4:0] walk_idx;
   logic [STEP_W-1:0] step_cnt;
   logic [7:0] crc;
   logic [7:0] stored_crc;
   logic miso, miso_oe_n, miso_weak_pd, in_pull_en, err, nvm_busy;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   sef_sync #(.WIDTH(4), .RESET_VAL(4'h8)) u_sync (
      .CLOCK(CLOCK),
      .NRST(NRST),
      .D({LINK.cs_n, LINK.sclk, LINK.mosi, NVM_FAULT}),
      .Q({cs_s, sclk_s, mosi_s, fault_s})
   );

   // ----------------------------------------
   // Frame decode
   // ----------------------------------------
   wire cs_fall = cs_prev & ~cs_s;
   wire cs_rise = ~cs_prev & cs_s;
   wire sclk_rise = ~sclk_prev & sclk_s & ~cs_s;
   wire sclk_fall = sclk_prev & ~sclk_s & ~cs_s;
   wire frame16 = bit_cnt == 5'd16;
   wire frame17 = bit_cnt == 5'd17;
   wire [15:0] cmd = frame17 ? rx_shift[16:1] : rx_shift[15:0];
   wire [2:0] op = cmd[OP_MSB:OP_LSB];
   wire [4:0] addr = cmd[ADDR_MSB:ADDR_LSB];
   wire [7:0] wdata = cmd[DATA_MSB:0];
   wire exec = cs_rise & (frame16 | frame17);
   wire is_write = exec & (op == OP_WRITE_REG);
   wire mode17 = regs[REG_PADCFG][PAD_MODE17_BIT];
   wire nv_active = nv_st != NV_IDLE;
   // Even parity over all 17 bits; other commands pass unchecked
   wire parity_bad = mode17 & ~(frame17 & ~^rx_shift); // [RULE_02] [RULE_01]
   wire set_par = is_write & parity_bad; // [RULE_03]
   wire set_mem = is_write & nv_active; // [RULE_04]
   wire wr_ok = is_write & ~parity_bad & ~nv_active & (addr != REG_ERR); // [RULE_03]
   wire store_go = exec & (op == OP_STORE_ALL) & ~nv_active;
   wire restore_go = exec & (op == OP_RESTORE_ALL) & ~nv_active;
   wire clear_go = exec & (op == OP_CLEAR_ERR);

   // ----------------------------------------
   // Restore / store walk
   // ----------------------------------------
   wire restoring = nv_st == NV_RESTORE;
   wire walk_last = walk_idx == 5'(NUM_REGS - 1);
   // Each entry takes a fixed number of cycles, as slow memory would
   wire step_end = step_cnt == STEP_W'(NVM_STEP_CYC - 1);
   wire [7:0] nvm_rd = nvm[walk_idx] ^ {7'h00, fault_s & restoring};
   wire [7:0] crc_step = sef_crc8(crc, nvm_rd);
   wire set_crc = restoring & walk_last & step_end & (crc_step != stored_crc); // [RULE_07]
   wire [2:0] set_vec = {set_crc, set_mem, set_par};
   // Set wins over a clear arriving in the same cycle
   wire [2:0] next_flags = set_vec | (flags & ~{3{clear_go}}); // [RULE_09] [RULE_14]
   wire [7:0] rd_val = (addr == REG_ERR) ? {5'h00, flags} : regs[addr]; // [RULE_13]
   wire [15:0] next_resp = wr_ok ? {8'h00, wdata} : {8'h00, rd_val};

   // ----------------------------------------
   // Edge history
   // ----------------------------------------
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         cs_prev <= 1'b1;
         sclk_prev <= 1'b0;
      end else begin
         cs_prev <= cs_s;
         sclk_prev <= sclk_s;
      end
   end

   // Receive shifter on clock rising edges
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         rx_shift <= '0;
         bit_cnt <= '0;
      end else if (cs_fall) begin
         rx_shift <= '0;
         bit_cnt <= '0;
      end else if (sclk_rise) begin
         rx_shift <= {rx_shift[15:0], mosi_s};
         bit_cnt <= (bit_cnt == 5'h1F) ? bit_cnt : bit_cnt + 5'd1;
      end
   end

   // Transmit shifter, answer of the previous frame
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         tx_shift <= '0;
         miso <= 1'b0;
      end else if (cs_fall) begin
         tx_shift <= resp;
         miso <= resp[15];
      end else if (sclk_fall) begin
         tx_shift <= {tx_shift[14:0], 1'b0};
         miso <= tx_shift[14];
      end
   end

   // Response kept for the next frame
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         resp <= '0;
      end else if (exec) begin
         resp <= next_resp;
      end
   end

   // Sticky error flags
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         flags <= '0;
      end else begin
         flags <= next_flags; // [RULE_14]
      end
   end

   // ----------------------------------------
   // Register file and memory image
   // ----------------------------------------
   for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
      localparam logic [7:0] RST = (g == int'(REG_PADCFG)) ? PADCFG_RESET : 8'h00;
      always_ff @(posedge CLOCK) begin
         if (!NRST) begin
            regs[g] <= RST;
            nvm[g] <= NVM_RESET;
         end else begin
            if (wr_ok && addr == 5'(g)) begin
               regs[g] <= wdata;
            end else if (restoring && step_end && walk_idx == 5'(g)) begin
               regs[g] <= nvm_rd;
            end
            if (store_go) begin
               nvm[g] <= regs[g];
            end
         end
      end
   end

   // Memory walk: one entry per step, CRC accumulated
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         nv_st <= NV_IDLE;
         walk_idx <= '0;
         step_cnt <= '0;
         crc <= CRC_INIT;
      end else begin
         case (nv_st)
            NV_IDLE: begin
               walk_idx <= '0;
               step_cnt <= '0;
               crc <= CRC_INIT;
               if (store_go) begin
                  nv_st <= NV_STORE;
               end else if (restore_go) begin
                  nv_st <= NV_RESTORE;
               end
            end
            NV_STORE, NV_RESTORE: begin
               step_cnt <= step_end ? '0 : step_cnt + STEP_W'(1);
               if (step_end) begin
                  crc <= crc_step; // [RULE_07]
                  walk_idx <= walk_idx + 5'd1;
                  if (walk_last) begin
                     nv_st <= NV_IDLE;
                  end
               end
            end
            default: begin
               nv_st <= NV_IDLE;
            end
         endcase
      end
   end

   // Checksum saved with a store
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         stored_crc <= CRC_INIT;
      end else if (nv_st == NV_STORE && walk_last && step_end) begin
         stored_crc <= crc_step;
      end
   end

   // ----------------------------------------
   // Pins
   // ----------------------------------------
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         miso_oe_n <= 1'b1;
         miso_weak_pd <= 1'b1;
         in_pull_en <= 1'b1;
         err <= 1'b0;
         nvm_busy <= 1'b0;
      end else begin
         miso_oe_n <= cs_s; // [RULE_11]
         miso_weak_pd <= cs_s & ~regs[REG_PADCFG][PAD_FLOAT_BIT]; // [RULE_12]
         in_pull_en <= regs[REG_PADCFG][PAD_PULL_BIT]; // [RULE_10]
         err <= |flags; // [RULE_08] [RULE_09]
         nvm_busy <= nv_active;
      end
   end

   assign LINK.miso = miso;
   assign LINK.miso_oe_n = miso_oe_n;
   assign LINK.miso_weak_pd = miso_weak_pd;
   assign LINK.in_pull_en = in_pull_en;
   assign LINK.err = err;
   assign LINK.nvm_busy = nvm_busy;
endmodule

// [pkg/sef_pkg.sv]
package sef_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int SCLK_PERIOD_NS = 400;
   localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   // Cycles per memory entry, long enough that a whole frame fits inside a walk
   localparam int NVM_STEP_CYC = 16;
   // ----------------------------------------
   // Command word layout
   // ----------------------------------------
   localparam int CMD_W = 16;
   localparam int OP_MSB = 15;
   localparam int OP_LSB = 13;
   localparam int ADDR_MSB = 12;
   localparam int ADDR_LSB = 8;
   localparam int DATA_MSB = 7;
   localparam logic [2:0] OP_READ_REG = 3'h2;
   localparam logic [2:0] OP_WRITE_REG = 3'h4;
   localparam logic [2:0] OP_RESTORE_ALL = 3'h5;
   localparam logic [2:0] OP_STORE_ALL = 3'h6;
   localparam logic [2:0] OP_CLEAR_ERR = 3'h7;
   // ----------------------------------------
   // Device registers
   // ----------------------------------------
   localparam int NUM_REGS = 32;
   localparam logic [4:0] REG_ERR = 5'h1A;
   localparam logic [4:0] REG_PADCFG = 5'h0E;
   localparam int PAD_FLOAT_BIT = 0;
   localparam int PAD_PULL_BIT = 1;
   localparam int PAD_MODE17_BIT = 2;
   localparam logic [7:0] PADCFG_RESET = 8'h02;
   localparam int ERR_PAR_BIT = 0;
   localparam int ERR_MEM_BIT = 1;
   localparam int ERR_CRC_BIT = 2;
   localparam logic [7:0] NVM_RESET = 8'h00;
   localparam logic [7:0] CRC_INIT = 8'h00;
   localparam logic [7:0] CRC_POLY = 8'h07;
   // ----------------------------------------
   // Controller APB registers
   // ----------------------------------------
   localparam logic [11:0] HOST_CMD_OFF = 12'h000;
   localparam logic [11:0] HOST_STAT_OFF = 12'h004;
   localparam logic [11:0] HOST_INT_OFF = 12'h008;
   localparam logic [11:0] HOST_MASK_OFF = 12'h00C;
   localparam int CMD_LEN17_BIT = 16;
   localparam int INT_DONE_BIT = 0;
   localparam int INT_ERR_BIT = 1;
   localparam int INT_MIS_BIT = 2;

   // One byte step of the CRC over the register image
   function automatic logic [7:0] sef_crc8(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int k = 0; k < 8; k++) begin
         c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      return c;
   endfunction
endpackage

// [pkg/sef_link_if.sv]
interface sef_link_if;
   logic cs_n;
   logic sclk;
   logic mosi;
   logic miso;
   logic miso_oe_n;
   logic miso_weak_pd;
   logic in_pull_en;
   logic err;
   logic nvm_busy;
   modport dev (input cs_n, input sclk, input mosi, output miso, output miso_oe_n,
      output miso_weak_pd, output in_pull_en, output err, output nvm_busy);
   modport ctl (output cs_n, output sclk, output mosi, input miso, input miso_oe_n,
      input miso_weak_pd, input in_pull_en, input err, input nvm_busy);
endinterface

// [rtl/sef_sync.sv]
module sef_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic CLOCK,
   input wire logic NRST,
   input wire logic [WIDTH-1:0] D,
   output logic [WIDTH-1:0] Q
);
   logic [WIDTH-1:0] meta;

   // Two-stage synchroniser, first stage read only by the second
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         meta <= RESET_VAL;
         Q <= RESET_VAL;
      end else begin
         meta <= D;
         Q <= meta;
      end
   end
endmodule

// [rtl/sef_ctl.sv]
module sef_ctl (
   input wire logic CLOCK,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic IRQ,
   sef_link_if.ctl LINK
);
   import sef_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   typedef enum logic [2:0] {H_IDLE, H_WAIT, H_LEAD, H_HIGH, H_LOW, H_TAIL, H_GAP} sef_h_e;
   sef_h_e st;
   logic miso_s, err_s, nvm_s, err_prev;
   logic [3:0] cnt;
   logic [16:0] tx;
   logic [4:0] bits_left;
   logic [4:0] rx_cnt;
   logic [15:0] rx, last_resp;
   logic cur_write, prev_write;
   logic [7:0] cur_wdata, prev_wdata;
   logic [2:0] int_status, int_mask;
   logic cs_n, sclk, mosi;

   sef_sync #(.WIDTH(3)) u_sync (
      .CLOCK(CLOCK),
      .NRST(NRST),
      .D({LINK.miso, LINK.err, LINK.nvm_busy}),
      .Q({miso_s, err_s, nvm_s})
   );

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   wire acc = PSEL & PENABLE;
   wire next_pready = acc & ~PREADY;
   wire wr = acc & PREADY & PWRITE;
   wire sel_cmd = PADDR == HOST_CMD_OFF;
   wire sel_stat = PADDR == HOST_STAT_OFF;
   wire sel_int = PADDR == HOST_INT_OFF;
   wire sel_mask = PADDR == HOST_MASK_OFF;
   wire mapped = sel_cmd | sel_stat | sel_int | sel_mask;
   wire busy = st != H_IDLE;
   wire start = wr & sel_cmd & ~busy;
   wire [2:0] op = PWDATA[OP_MSB:OP_LSB];
   wire len17 = PWDATA[CMD_LEN17_BIT] & (op == OP_WRITE_REG); // [RULE_01]
   wire [31:0] rd_mux = sel_stat ? {last_resp, 13'h0000, nvm_s, err_s, busy} :
                        sel_int ? {29'h0, int_status} :
                        sel_mask ? {29'h0, int_mask} : 32'h0;
   wire half_done = cnt == 4'(SCLK_HALF_CYC - 1);
   wire frame_done = (st == H_GAP) & half_done;
   wire ev_mis = frame_done & prev_write & (rx[7:0] != prev_wdata); // [RULE_06]
   wire [2:0] ev = {ev_mis, err_s & ~err_prev, frame_done};
   wire [2:0] w1c = (wr & sel_int) ? PWDATA[2:0] : 3'h0;

   // Bus answer registers
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= '0;
      end else begin
         PREADY <= next_pready;
         PSLVERR <= next_pready & ~mapped;
         PRDATA <= (next_pready & ~PWRITE) ? rd_mux : 32'h0;
      end
   end

   // Sticky events, set wins over write-one-clear
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         int_status <= '0;
         int_mask <= '0;
         err_prev <= 1'b0;
         IRQ <= 1'b0;
      end else begin
         int_status <= ev | (int_status & ~w1c);
         if (wr & sel_mask) begin
            int_mask <= PWDATA[2:0];
         end
         err_prev <= err_s;
         IRQ <= |(int_status & int_mask);
      end
   end

   // ----------------------------------------
   // Link sequencer
   // ----------------------------------------
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         st <= H_IDLE;
         cnt <= '0;
         cs_n <= 1'b1;
         sclk <= 1'b0;
         mosi <= 1'b0;
         tx <= '0;
         bits_left <= '0;
         rx_cnt <= '0;
         rx <= '0;
         cur_write <= 1'b0;
         cur_wdata <= '0;
      end else begin
         cnt <= (st == H_IDLE || st == H_WAIT || half_done) ? 4'h0 : cnt + 4'h1;
         case (st)
            H_IDLE: begin
               if (start) begin
                  tx <= {PWDATA[15:0], len17 ? ^PWDATA[15:0] : 1'b0}; // [RULE_01]
                  bits_left <= len17 ? 5'd17 : 5'd16;
                  cur_write <= op == OP_WRITE_REG;
                  cur_wdata <= PWDATA[DATA_MSB:0];
                  rx_cnt <= '0;
                  st <= H_WAIT;
               end
            end
            H_WAIT: begin
               if (!(cur_write && nvm_s)) begin // [RULE_05]
                  cs_n <= 1'b0;
                  mosi <= tx[16];
                  st <= H_LEAD;
               end
            end
            H_LEAD, H_LOW: begin
               if (half_done) begin
                  sclk <= 1'b1;
                  st <= H_HIGH;
               end
            end
            H_HIGH: begin
               if (half_done) begin
                  sclk <= 1'b0;
                  if (rx_cnt < 5'd16) begin
                     rx <= {rx[14:0], miso_s};
                     rx_cnt <= rx_cnt + 5'd1;
                  end
                  if (bits_left == 5'd1) begin
                     st <= H_TAIL;
                  end else begin
                     tx <= {tx[15:0], 1'b0};
                     mosi <= tx[15];
                     bits_left <= bits_left - 5'd1;
                     st <= H_LOW;
                  end
               end
            end
            H_TAIL: begin
               if (half_done) begin
                  cs_n <= 1'b1;
                  st <= H_GAP;
               end
            end
            H_GAP: begin
               if (half_done) begin
                  st <= H_IDLE;
               end
            end
            default: begin
               st <= H_IDLE;
            end
         endcase
      end
   end

   // Previous frame record for the write read-back check
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         last_resp <= '0;
         prev_write <= 1'b0;
         prev_wdata <= '0;
      end else if (frame_done) begin
         last_resp <= rx;
         prev_write <= cur_write; // [RULE_06]
         prev_wdata <= cur_wdata;
      end
   end

   assign LINK.cs_n = cs_n;
   assign LINK.sclk = sclk;
   assign LINK.mosi = mosi;
endmodule

// [verif/sef_link_props.sv]
module sef_link_props (
   input wire logic CLOCK,
   input wire logic NRST,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic miso_oe_n,
   input wire logic miso_weak_pd,
   input wire logic in_pull_en,
   input wire logic err,
   input wire logic nvm_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   import sef_pkg::*;
   // ----------------------------------------
   // Link checks
   // ----------------------------------------
   default clocking @(posedge CLOCK);
   endclocking
   default disable iff (!NRST);

   logic [4:0] edges;
   int busy_len;

   // Counts cycles of one memory walk
   always_ff @(posedge CLOCK) begin
      if (!NRST || !nvm_busy) begin
         busy_len <= 0;
      end else begin
         busy_len <= busy_len + 1;
      end
   end

   // Counts link clock rises inside a frame
   always_ff @(posedge CLOCK) begin
      if (!NRST || cs_n) begin
         edges <= 5'h00;
      end else if ($rose(sclk)) begin
         edges <= edges + 5'h01;
      end
   end

   // Frame length, pin driving and flag behaviour
   frame_len_a: assert property ($rose(cs_n) |-> edges == 5'h10 || edges == 5'h11)
      else $error("frame length is not 16 or 17 bits");
   oe_active_a: assert property ((!cs_n)[*6] |-> !miso_oe_n)
      else $error("data out not driven during frame");
   oe_idle_a: assert property (cs_n[*6] |-> miso_oe_n)
      else $error("data out still driven while idle");
   err_rise_a: assert property ($rose(err) |-> cs_n || $past(nvm_busy))
      else $error("error pin rose without a cause");
   flags_sticky_a: assert property ((err && cs_n)[*8] |=> err)
      else $error("error pin dropped without clear");
   pull_update_a: assert property (
      $changed(in_pull_en) |-> cs_n || nvm_busy || $past(nvm_busy))
      else $error("input pull setting changed mid frame");
   pd_frame_a: assert property ((!cs_n)[*6] |-> !miso_weak_pd)
      else $error("idle pull-down still on during frame");
   nvm_walk_a: assert property (
      $fell(nvm_busy) |-> busy_len == NUM_REGS * NVM_STEP_CYC)
      else $error("memory walk length out of range");
endmodule

// [verif/test_spi_error_flags_pin_config.sv]
module test_spi_error_flags_pin_config;
   timeunit 1ns;
   timeprecision 1ns;
   import sef_pkg::*;
   // ----------------------------------------
   // Bench signals and instances
   // ----------------------------------------
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic nvm_fault = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic [31:0] rd;
   logic slverr;
   int err_total = 0;
   int tests_run = 0;
   int polls = 0;

   sef_link_if ifa();
   sef_link_if ifb();

   sef_dev i_sef_dev (.CLOCK(clock), .NRST(nrst), .NVM_FAULT(nvm_fault), .LINK(ifa.dev));
   sef_ctl i_sef_ctl (.CLOCK(clock), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .IRQ(irq), .LINK(ifa.ctl));
   // Second device end faced by the bench's own frame driver
   sef_dev i_sef_dev_b (.CLOCK(clock), .NRST(nrst), .NVM_FAULT(1'b0), .LINK(ifb.dev));
   sef_link_props i_sef_link_props (.CLOCK(clock), .NRST(nrst), .cs_n(ifa.cs_n),
      .sclk(ifa.sclk), .miso_oe_n(ifa.miso_oe_n), .miso_weak_pd(ifa.miso_weak_pd),
      .in_pull_en(ifa.in_pull_en), .err(ifa.err), .nvm_busy(ifa.nvm_busy));

   // Clock and watchdog
   always #25 clock = ~clock;
   initial begin
      repeat (100000) @(posedge clock);
      err_total++;
      wrap_up();
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic wrap_up();
      if (err_total == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
         err_total++;
      end
   endtask

   // Bounded wait step; running out ends the run
   task automatic guard(inout int n);
      n++;
      if (n > 250) begin
         err_total++;
         wrap_up();
      end
   endtask

   // One APB transfer, held until ready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         guard(n);
      end while (pready !== 1'b1);
      rd = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Sends one command frame and waits for two idle status reads in a row, so that
   // a memory walk whose busy pin is still in the synchroniser is not missed
   task automatic cmd(input logic [2:0] op, input logic [4:0] a, input logic [7:0] d,
      input logic l17);
      int n;
      int idle;
      n = 0;
      idle = 0;
      apb(1'b1, HOST_CMD_OFF, {15'h0, l17, op, a, d});
      while (idle < 2) begin
         apb(1'b0, HOST_STAT_OFF, 32'h0);
         idle = (rd[0] === 1'b0 && rd[2] === 1'b0) ? idle + 1 : 0;
         guard(n);
      end
   endtask

   // Reads a device register; the answer arrives in the following frame
   task automatic dev_rd(input logic [4:0] a, input logic [7:0] e);
      cmd(OP_READ_REG, a, 8'h00, 1'b0);
      cmd(OP_READ_REG, a, 8'h00, 1'b0);
      chk(32'(rd[31:16]), {24'h0, e});
   endtask

   // Raw frame on the second link, n bits MSB first from bit n-1
   task automatic frame_b(input logic [16:0] w, input int n);
      @(posedge clock);
      ifb.cs_n <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         repeat (SCLK_HALF_CYC) @(posedge clock);
         ifb.mosi <= w[i];
         repeat (SCLK_HALF_CYC) @(posedge clock);
         ifb.sclk <= 1'b1;
         repeat (SCLK_HALF_CYC) @(posedge clock);
         ifb.sclk <= 1'b0;
      end
      repeat (SCLK_HALF_CYC) @(posedge clock);
      ifb.cs_n <= 1'b1;
      ifb.mosi <= ~w[0];
      repeat (2 * SCLK_HALF_CYC) @(posedge clock);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      ifb.cs_n <= 1'b1;
      ifb.sclk <= 1'b0;
      ifb.mosi <= 1'b0;
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      chk(32'({ifa.in_pull_en, ifa.miso_weak_pd, ifa.miso_oe_n, ifa.err}), 32'hE);
      dev_rd(REG_PADCFG, PADCFG_RESET);
      dev_rd(REG_ERR, 8'h00);
      apb(1'b0, 12'h010, 32'h0);
      chk(32'(slverr), 32'h1);
      // Pad settings: float and no pulls, then pulls with 17-bit mode
      cmd(OP_WRITE_REG, REG_PADCFG, 8'h01, 1'b0);
      chk(32'({ifa.in_pull_en, ifa.miso_weak_pd}), 32'h0);
      cmd(OP_WRITE_REG, REG_PADCFG, 8'h06, 1'b0);
      chk(32'({ifa.in_pull_en, ifa.miso_weak_pd}), 32'h3);
      // Only the error-rise interrupt is unmasked
      apb(1'b1, HOST_MASK_OFF, 32'h2);
      apb(1'b1, HOST_INT_OFF, 32'h7);
      cmd(OP_WRITE_REG, 5'h03, 8'hA5, 1'b1);
      dev_rd(5'h03, 8'hA5);
      chk(32'(ifa.err), 32'h0);
      // Write without parity bit in 17-bit mode is discarded
      cmd(OP_WRITE_REG, 5'h03, 8'h5A, 1'b0);
      dev_rd(5'h03, 8'hA5);
      dev_rd(REG_ERR, 8'h01);
      chk(32'(rd[1]), 32'h1);
      chk(32'(irq), 32'h1);
      // Read-back of the discarded write differs from its data
      apb(1'b0, HOST_INT_OFF, 32'h0);
      chk(32'(rd[2:1]), 32'h3);
      apb(1'b1, HOST_INT_OFF, 32'h2);
      repeat (2) @(posedge clock);
      chk(32'(irq), 32'h0);
      cmd(OP_CLEAR_ERR, 5'h00, 8'h00, 1'b0);
      chk(32'(ifa.err), 32'h0);
      dev_rd(REG_ERR, 8'h00);
      // Store, clean restore, then corrupted restore
      apb(1'b1, HOST_CMD_OFF, {16'h0, OP_STORE_ALL, 13'h0000});
      do begin
         apb(1'b0, HOST_STAT_OFF, 32'h0);
         guard(polls);
      end while (rd[2] !== 1'b1);
      // Write held back by the controller until the memory walk ends
      cmd(OP_WRITE_REG, 5'h04, 8'h3C, 1'b1);
      dev_rd(REG_ERR, 8'h00);
      cmd(OP_RESTORE_ALL, 5'h00, 8'h00, 1'b0);
      dev_rd(5'h03, 8'hA5);
      dev_rd(REG_ERR, 8'h00);
      nvm_fault <= 1'b1;
      cmd(OP_RESTORE_ALL, 5'h00, 8'h00, 1'b0);
      nvm_fault <= 1'b0;
      dev_rd(REG_ERR, 8'h04);
      chk(32'(ifa.err), 32'h1);
      cmd(OP_CLEAR_ERR, 5'h00, 8'h00, 1'b0);
      // Second link: true 17-bit frames with bad and good parity
      frame_b({1'b0, OP_WRITE_REG, REG_PADCFG, 8'h06}, 16);
      frame_b({OP_WRITE_REG, 5'h03, 8'h01, 1'b1}, 17);
      chk(32'(ifb.err), 32'h1);
      frame_b({1'b0, OP_CLEAR_ERR, 5'h00, 8'h00}, 16);
      chk(32'(ifb.err), 32'h0);
      // Good-parity write sent during a store walk
      frame_b({1'b0, OP_STORE_ALL, 5'h00, 8'h00}, 16);
      frame_b({OP_WRITE_REG, 5'h03, 8'h01, 1'b0}, 17);
      chk(32'(ifb.err), 32'h1);
      repeat (NUM_REGS * NVM_STEP_CYC) @(posedge clock);
      frame_b({1'b0, OP_CLEAR_ERR, 5'h00, 8'h00}, 16);
      chk(32'(ifb.err), 32'h0);
      frame_b({OP_WRITE_REG, 5'h03, 8'h01, 1'b0}, 17);
      frame_b({OP_READ_REG, 5'h03, 8'h00, 1'b0}, 17);
      chk(32'(ifb.err), 32'h0);
      wrap_up();
   end
endmodule
